//--- logic/csis_pkg.sv
// Shared constants and types of the stack and interrupt sequencer.
package csis_pkg;

    // ------------------------------------------------------------
    // I/O map and field layout
    // ------------------------------------------------------------
    localparam logic [5:0] STACK_POINTER_LOW_BYTE_ADDR = 6'h3d;
    localparam logic [5:0] STACK_POINTER_HIGH_BYTE_ADDR = 6'h3e;
    localparam logic [5:0] CPU_FLAGS_REGISTER_ADDR = 6'h3f;
    localparam int GIE_BIT = 7;
    localparam int ZERO_BIT = 1;
    localparam int CARRY_BIT = 0;
    localparam logic [7:0] CPU_FLAGS_RESET = 8'h00;

    // ------------------------------------------------------------
    // Sizes, reset values and cycle counts
    // ------------------------------------------------------------
    localparam int SRC_NUM = 8;
    localparam int VEC_W = 4;
    localparam int SP_BITS = 10;
    localparam logic [15:0] TOP_OF_DATA_RAM = 16'h025f;
    localparam int ENTRY_CYCLES = 4;
    localparam int RETURN_CYCLES = 4;
    localparam int WAKE_EXTRA_CYCLES = 4;
    localparam logic [2:0] WAKE_LAST = 3'(WAKE_EXTRA_CYCLES - 1);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_PUSH1, OP_POP1, OP_CALL, OP_RET, OP_RETURN_FROM_HANDLER_INSTR, OP_SEI,
        OP_CLI
    } csis_op_e;

    typedef enum logic [2:0] {
        ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR
    } csis_alu_e;

    typedef struct packed {
        logic valid;
        csis_op_e op;
        logic [7:0] data;
    } csis_op_s;

    typedef struct packed {
        logic we;
        logic re;
        logic [5:0] addr;
        logic [7:0] wdata;
    } csis_io_s;

    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } csis_mem_s;

    typedef struct packed {
        logic valid;
        csis_alu_e op;
        logic [7:0] a;
        logic [7:0] b;
    } csis_alu_s;

endpackage

//--- logic/csis_sequencer.sv
// Stack pointer, interrupt gating and entry/return sequencing of the CPU.
//
// Functional notes
// RULE_01: Stack grows downward; pointer marks top.
// RULE_02: Push lowers by one; call/entry by two.
// RULE_03: Pop raises by one; return by two.
// RULE_04: Software sets pointer above 0x60 first.
// RULE_05: Pointer is two 8-bit I/O registers.
// RULE_06: Logic runs on undivided CPU clock.
// RULE_07: Two-operand ALU result written in one cycle.
// RULE_08: Serve only if own and global enable.
// RULE_09: Lowest vector wins; reset then request zero.
// RULE_10: Accepting interrupt clears global enable.
// RULE_11: Vectoring clears the source's flag.
// RULE_12: Writing one clears flag; zero ignored.
// RULE_13: Disabled flags stay pending, served by priority.
// RULE_14: Level source requests only while present.
// RULE_15: One instruction runs after handler return.
// RULE_16: Flags register not saved nor restored.
// RULE_17: Global disable acts at once, same cycle.
// RULE_18: Instruction after global enable runs first.
// RULE_19: Entry takes four cycles, pushing return address.
// RULE_20: Multi-cycle instruction completes before entry.
// RULE_21: Wake from sleep adds four cycles.
// RULE_22: Return takes four cycles, pops, sets enable.
// RULE_23: Global enable is flags bit seven.
// RULE_24: Unimplemented pointer bits read zero.
module csis_sequencer (
    input wire logic SYS_CLK, // CPU clock
    input wire logic RSTN, // async reset, active low
    input wire csis_pkg::csis_io_s IO_REQ, // I/O space access
    output logic [7:0] IO_RDATA, // I/O read data
    input wire csis_pkg::csis_op_s OP_REQ, // stack or flag instruction
    output logic OP_DONE, // instruction sequence finished
    output logic [7:0] POP_DATA, // byte popped by single pop
    input wire logic [15:0] PC_IN, // return address of the instruction
    input wire logic INSTR_END, // instruction boundary
    input wire logic SLEEPING, // core is asleep
    input wire logic [7:0] IRQ_EVENT, // event sources, flag setting
    input wire logic [7:0] IRQ_COND, // level source conditions
    input wire logic [7:0] IRQ_IS_LEVEL, // source is level type
    input wire logic [7:0] IRQ_ENABLE, // individual enables
    input wire logic [7:0] IRQ_FLAG_W1C, // write one to clear flags
    output logic [7:0] IRQ_FLAGS, // pending event flags
    input wire csis_pkg::csis_alu_s ALU_REQ, // two-operand operation
    output logic [7:0] ALU_RESULT, // result for destination register
    output logic ALU_RESULT_VALID, // result written this cycle
    output csis_pkg::csis_mem_s MEM, // stack SRAM access
    input wire logic [7:0] MEM_RDATA, // SRAM data, one cycle after read
    output logic [15:0] PC_OUT, // value to load into the PC
    output logic PC_LOAD, // load PC_OUT this cycle
    output logic [3:0] VECTOR_NUM, // vector of the accepted request
    output logic STALL, // core must hold its pipeline
    output logic GLOBAL_IRQ_ENABLE // global enable bit
);
    import csis_pkg::*;

    typedef enum {
        ST_IDLE, ST_WAKE, ST_ENT_LO, ST_ENT_HI, ST_ENT_VEC, ST_PUSH,
        ST_POP_CAP, ST_CALL_LO, ST_CALL_HI, ST_RET_A, ST_RET_B, ST_RET_END
    } csis_state_e;

    csis_state_e state_ff;
    csis_state_e nxt_state;
    logic [SP_BITS-1:0] sp_ff;
    logic [15:0] sp16;
    logic [7:0] flags_ff;
    logic [SRC_NUM-1:0] flag_ff;
    logic [SRC_NUM-1:0] req;
    logic [SRC_NUM-1:0] clr_take;
    logic [VEC_W-1:0] win_vec;
    logic [2:0] win_idx;
    logic any_req;
    logic [15:0] ret_pc_ff;
    logic [7:0] data_ff;
    logic [7:0] pc_hi_ff;
    logic [15:0] pc_out_ff;
    logic pc_load_ff;
    logic [VEC_W-1:0] vec_ff;
    logic [2:0] wake_ff;
    logic is_return_from_handler_instr_ff;
    logic [7:0] rdata_ff;
    logic [7:0] pop_ff;
    logic [7:0] alu_ff;
    logic alu_valid_ff;
    logic [8:0] alu_sum;
    logic idle;
    logic acc;
    logic seq_op;
    logic cli_now;
    logic take;

    // ------------------------------------------------------------
    // Request gating and priority
    // ------------------------------------------------------------
    // Every flop below runs straight off SYS_CLK with no divider.
    // RULE_06 undivided CPU clock
    assign sp16 = {{(16 - SP_BITS){1'b0}}, sp_ff};
    assign idle = (state_ff == ST_IDLE);
    assign seq_op = OP_REQ.valid && (OP_REQ.op inside {OP_PUSH1, OP_POP1,
        OP_CALL, OP_RET, OP_RETURN_FROM_HANDLER_INSTR});
    assign acc = idle && OP_REQ.valid;
    // RULE_17 disable acts immediately
    assign cli_now = (OP_REQ.valid && OP_REQ.op == OP_CLI) || (IO_REQ.we
        && IO_REQ.addr == CPU_FLAGS_REGISTER_ADDR && !IO_REQ.wdata[GIE_BIT]);

    genvar gi;
    generate
        for (gi = 0; gi < SRC_NUM; gi++) begin : g_src
            // RULE_14 level request while present
            // RULE_08 own and global enable
            assign req[gi] = IRQ_ENABLE[gi] && (IRQ_IS_LEVEL[gi] ?
                IRQ_COND[gi] : flag_ff[gi]);
            assign clr_take[gi] = take && win_idx == 3'(gi)
                && !IRQ_IS_LEVEL[gi];
            // RULE_12 write one clears
            // RULE_11 vectoring clears flag
            // RULE_13 flag stays pending
            always_ff @(posedge SYS_CLK or negedge RSTN) begin
                if (!RSTN) begin
                    flag_ff[gi] <= 1'b0;
                end else begin
                    flag_ff[gi] <= (flag_ff[gi] && !clr_take[gi]
                        && !IRQ_FLAG_W1C[gi]) || IRQ_EVENT[gi];
                end
            end
        end
    endgenerate

    // RULE_09 lowest vector wins
    always_comb begin
        win_idx = 3'd0;
        any_req = 1'b0;
        for (int i = SRC_NUM - 1; i >= 0; i--) begin
            if (req[i]) begin
                win_idx = 3'(i);
                any_req = 1'b1;
            end
        end
    end
    // Vector 0 belongs to reset, so source n sits at vector n + 1.
    assign win_vec = VEC_W'({1'b0, win_idx} + 4'h1);

    // RULE_20 only at a boundary
    // RULE_18 uses the enable before this cycle
    // RULE_15 return ends outside idle
    assign take = idle && (INSTR_END || SLEEPING) && !seq_op && !cli_now
        && flags_ff[GIE_BIT] && any_req;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_state = SLEEPING ? ST_WAKE : ST_ENT_LO;
                end else if (acc) begin
                    case (OP_REQ.op)
                        OP_PUSH1: nxt_state = ST_PUSH;
                        OP_POP1: nxt_state = ST_POP_CAP;
                        OP_CALL: nxt_state = ST_CALL_LO;
                        OP_RET, OP_RETURN_FROM_HANDLER_INSTR: nxt_state = ST_RET_A;
                        default: nxt_state = ST_IDLE;
                    endcase
                end
            end
            // RULE_21 four extra wake cycles
            ST_WAKE: nxt_state = (wake_ff == WAKE_LAST) ? ST_ENT_LO : ST_WAKE;
            ST_ENT_LO: nxt_state = ST_ENT_HI;
            ST_ENT_HI: nxt_state = ST_ENT_VEC;
            ST_CALL_LO: nxt_state = ST_CALL_HI;
            ST_RET_A: nxt_state = ST_RET_B;
            ST_RET_B: nxt_state = ST_RET_END;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wake_ff <= 3'h0;
        end else begin
            wake_ff <= (state_ff == ST_WAKE) ? wake_ff + 3'h1 : 3'h0;
        end
    end

    // Return address and operand are held for the whole sequence.
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ret_pc_ff <= 16'h0000;
            data_ff <= 8'h00;
            vec_ff <= 4'h0;
            is_return_from_handler_instr_ff <= 1'b0;
        end else if (idle) begin
            ret_pc_ff <= PC_IN;
            data_ff <= OP_REQ.data;
            is_return_from_handler_instr_ff <= OP_REQ.op == OP_RETURN_FROM_HANDLER_INSTR;
            if (take) begin
                vec_ff <= win_vec;
            end
        end
    end

    // ------------------------------------------------------------
    // Stack pointer and stack traffic
    // ------------------------------------------------------------
    // RULE_01 downward stack
    // RULE_02 lower by one or two
    // RULE_03 raise by one or two
    // RULE_05 two I/O bytes
    // RULE_24 missing bits dropped
    // Nothing checks the pointer against the SRAM floor; a pointer left
    // at or below the I/O area simply writes there.
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sp_ff <= TOP_OF_DATA_RAM[SP_BITS-1:0];
        end else begin
            case (state_ff)
                ST_PUSH: sp_ff <= sp_ff - SP_BITS'(1);
                ST_ENT_HI, ST_CALL_HI: sp_ff <= sp_ff - SP_BITS'(2);
                ST_POP_CAP: sp_ff <= sp_ff + SP_BITS'(1);
                ST_RET_B: sp_ff <= sp_ff + SP_BITS'(2);
                // A pointer write in mid-sequence would tear the stack
                // traffic in flight, so software writes land only at idle.
                default: begin
                    if (idle && IO_REQ.we) begin
                        if (IO_REQ.addr == STACK_POINTER_LOW_BYTE_ADDR) begin
                            sp_ff[7:0] <= IO_REQ.wdata;
                        end
                        if (IO_REQ.addr == STACK_POINTER_HIGH_BYTE_ADDR) begin
                            sp_ff[SP_BITS-1:8] <= IO_REQ.wdata[SP_BITS-9:0];
                        end
                    end
                end
            endcase
        end
    end

    // Low return byte goes to the higher address, so a pop after the
    // two-byte push meets the high byte first.
    // RULE_19 return address pushed
    always_comb begin
        MEM = '0;
        case (state_ff)
            ST_ENT_LO, ST_CALL_LO: begin
                MEM.we = 1'b1;
                MEM.addr = sp16;
                MEM.wdata = ret_pc_ff[7:0];
            end
            ST_ENT_HI, ST_CALL_HI: begin
                MEM.we = 1'b1;
                MEM.addr = sp16 - 16'h0001;
                MEM.wdata = ret_pc_ff[15:8];
            end
            ST_PUSH: begin
                MEM.we = 1'b1;
                MEM.addr = sp16;
                MEM.wdata = data_ff;
            end
            ST_IDLE: begin
                MEM.re = acc && !take && (OP_REQ.op inside {OP_POP1,
                    OP_RET, OP_RETURN_FROM_HANDLER_INSTR});
                MEM.addr = sp16 + 16'h0001;
            end
            ST_RET_A: begin
                MEM.re = 1'b1;
                MEM.addr = sp16 + 16'h0002;
            end
            default: MEM = '0;
        endcase
    end

    // RULE_22 return in four cycles
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pc_hi_ff <= 8'h00;
            pop_ff <= 8'h00;
            pc_out_ff <= 16'h0000;
            pc_load_ff <= 1'b0;
        end else begin
            pc_load_ff <= (state_ff == ST_ENT_HI) || (state_ff == ST_RET_B);
            if (state_ff == ST_RET_A) begin
                pc_hi_ff <= MEM_RDATA;
            end
            if (state_ff == ST_POP_CAP) begin
                pop_ff <= MEM_RDATA;
            end
            if (state_ff == ST_RET_B) begin
                pc_out_ff <= {pc_hi_ff, MEM_RDATA};
            end else if (state_ff == ST_ENT_HI) begin
                pc_out_ff <= {12'h000, vec_ff};
            end
        end
    end

    // ------------------------------------------------------------
    // Flags register and ALU
    // ------------------------------------------------------------
    always_comb begin
        case (ALU_REQ.op)
            ALU_ADD: alu_sum = {1'b0, ALU_REQ.a} + {1'b0, ALU_REQ.b};
            ALU_SUB: alu_sum = {1'b0, ALU_REQ.a} - {1'b0, ALU_REQ.b};
            ALU_AND: alu_sum = {1'b0, ALU_REQ.a & ALU_REQ.b};
            ALU_OR: alu_sum = {1'b0, ALU_REQ.a | ALU_REQ.b};
            default: alu_sum = {1'b0, ALU_REQ.a ^ ALU_REQ.b};
        endcase
    end

    // RULE_07 single-cycle write-back
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            alu_ff <= 8'h00;
            alu_valid_ff <= 1'b0;
        end else begin
            alu_ff <= alu_sum[7:0];
            alu_valid_ff <= ALU_REQ.valid;
        end
    end

    // The sequences never touch bits 6..0; handlers save them by hand.
    // RULE_16 no save or restore
    // RULE_23 enable at bit seven
    // RULE_10 entry clears enable
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            flags_ff <= CPU_FLAGS_RESET;
        end else begin
            if (IO_REQ.we && IO_REQ.addr == CPU_FLAGS_REGISTER_ADDR) begin
                flags_ff <= IO_REQ.wdata;
            end else if (ALU_REQ.valid) begin
                flags_ff[CARRY_BIT] <= alu_sum[8];
                flags_ff[ZERO_BIT] <= alu_sum[7:0] == 8'h00;
            end
            if (take) begin
                flags_ff[GIE_BIT] <= 1'b0;
            end else if (state_ff == ST_RET_B && is_return_from_handler_instr_ff) begin
                flags_ff[GIE_BIT] <= 1'b1;
            end else if (acc && OP_REQ.op == OP_SEI) begin
                flags_ff[GIE_BIT] <= 1'b1;
            end else if (acc && OP_REQ.op == OP_CLI) begin
                flags_ff[GIE_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_ff <= 8'h00;
        end else if (IO_REQ.re) begin
            case (IO_REQ.addr)
                STACK_POINTER_LOW_BYTE_ADDR: rdata_ff <= sp16[7:0];
                STACK_POINTER_HIGH_BYTE_ADDR: rdata_ff <= sp16[15:8];
                CPU_FLAGS_REGISTER_ADDR: rdata_ff <= flags_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign IO_RDATA = rdata_ff;
    assign POP_DATA = pop_ff;
    assign IRQ_FLAGS = flag_ff;
    assign ALU_RESULT = alu_ff;
    assign ALU_RESULT_VALID = alu_valid_ff;
    assign PC_OUT = pc_out_ff;
    assign PC_LOAD = pc_load_ff;
    assign VECTOR_NUM = vec_ff;
    assign STALL = !idle;
    assign GLOBAL_IRQ_ENABLE = flags_ff[GIE_BIT];
    assign OP_DONE = (state_ff inside {ST_PUSH, ST_POP_CAP, ST_CALL_HI,
        ST_RET_END}) || (acc && OP_REQ.op inside {OP_SEI, OP_CLI});

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    sequence s_entry_push;
        MEM.we ##1 MEM.we ##1 PC_LOAD;
    endsequence
    sequence s_ret_pop;
        MEM.re ##1 MEM.re ##2 PC_LOAD;
    endsequence

    property p_entry_time;
        (take && !SLEEPING) |=> s_entry_push;
    endproperty
    a_entry_time: assert property (p_entry_time) // RULE_19
        else $error("entry did not push and vector in four cycles");

    property p_push_one;
        (acc && !take && OP_REQ.op == OP_PUSH1) |=>
            ##1 (sp_ff == $past(sp_ff, 2) - SP_BITS'(1));
    endproperty
    a_push_one: assert property (p_push_one) // RULE_02
        else $error("push did not lower pointer by one");

    property p_ret_two;
        (acc && !take && OP_REQ.op inside {OP_RET, OP_RETURN_FROM_HANDLER_INSTR}) |->
            s_ret_pop ##0 (sp_ff == $past(sp_ff, 3) + SP_BITS'(2));
    endproperty
    a_ret_two: assert property (p_ret_two) // RULE_22
        else $error("return did not pop two bytes in four cycles");

    property p_gate;
        take |-> flags_ff[GIE_BIT] && IRQ_ENABLE[win_idx];
    endproperty
    a_gate: assert property (p_gate) // RULE_08
        else $error("request taken without both enables");

    property p_cli_block;
        (idle && OP_REQ.valid && OP_REQ.op == OP_CLI) |=>
            !GLOBAL_IRQ_ENABLE && !(state_ff inside {ST_WAKE, ST_ENT_LO});
    endproperty
    a_cli_block: assert property (p_cli_block) // RULE_17
        else $error("request taken with global disable");

    property p_gie_clear;
        take |=> !GLOBAL_IRQ_ENABLE;
    endproperty
    a_gie_clear: assert property (p_gie_clear) // RULE_10
        else $error("global enable still set after entry");

    property p_flag_clear;
        (take && !IRQ_IS_LEVEL[win_idx] && !IRQ_EVENT[win_idx]) |=>
            !flag_ff[$past(win_idx)];
    endproperty
    a_flag_clear: assert property (p_flag_clear) // RULE_11
        else $error("flag not cleared on vectoring");

    property p_sleep_time;
        (take && SLEEPING) |=> (state_ff == ST_WAKE) [*4] ##1 s_entry_push;
    endproperty
    a_sleep_time: assert property (p_sleep_time) // RULE_21
        else $error("wake entry missed the four extra cycles");

    property p_sp_upper;
        (IO_REQ.re && IO_REQ.addr == STACK_POINTER_HIGH_BYTE_ADDR) |=>
            IO_RDATA[7:SP_BITS-8] == '0;
    endproperty
    a_sp_upper: assert property (p_sp_upper) // RULE_24
        else $error("unimplemented pointer bits read nonzero");

endmodule

//--- bench/csis_sram_model.sv
// Data SRAM model that holds the stack behind the sequencer.
module csis_sram_model
    import csis_pkg::*;
(
    input wire logic sys_clk, // CPU clock
    input wire csis_pkg::csis_mem_s mem, // stack access
    output logic [7:0] mem_rdata // read data, one cycle later
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ram [0:1023];
    always @(posedge sys_clk) begin
        if (mem.we) begin
            ram[mem.addr[9:0]] <= mem.wdata;
        end
        // A released data line toggles, so stale bytes never look valid.
        mem_rdata <= mem.re ? ram[mem.addr[9:0]] : ~mem_rdata;
    end
endmodule

//--- bench/cpu_stack_interrupt_sequencer_tb_top.sv
// Self-checking bench of the stack and interrupt sequencer.
module cpu_stack_interrupt_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csis_pkg::*;
    localparam logic [5:0] A_L = STACK_POINTER_LOW_BYTE_ADDR;
    localparam logic [5:0] A_H = STACK_POINTER_HIGH_BYTE_ADDR;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    csis_io_s io;
    csis_op_s op;
    csis_alu_s alu;
    csis_mem_s mem;
    logic [7:0] io_rdata, pop_data, ev, cond, en, w1c, flags, alu_res;
    logic [7:0] mem_rdata, rd;
    logic [15:0] pc_in, pc_out, pc_seen, stk;
    logic [3:0] vec;
    logic op_done, iend, sleeping, alu_v, pc_load, stall, gie;
    int n_mismatch = 0;
    int comparisons = 0;
    int n;

    always #4 clk = ~clk;

    csis_sequencer dut (
        .SYS_CLK(clk), .RSTN(rstn), .IO_REQ(io), .IO_RDATA(io_rdata),
        .OP_REQ(op), .OP_DONE(op_done), .POP_DATA(pop_data),
        .PC_IN(pc_in), .INSTR_END(iend), .SLEEPING(sleeping),
        .IRQ_EVENT(ev), .IRQ_COND(cond), .IRQ_IS_LEVEL(8'h01),
        .IRQ_ENABLE(en), .IRQ_FLAG_W1C(w1c), .IRQ_FLAGS(flags),
        .ALU_REQ(alu), .ALU_RESULT(alu_res), .ALU_RESULT_VALID(alu_v),
        .MEM(mem), .MEM_RDATA(mem_rdata), .PC_OUT(pc_out),
        .PC_LOAD(pc_load), .VECTOR_NUM(vec), .STALL(stall),
        .GLOBAL_IRQ_ENABLE(gie)
    );
    csis_sram_model sram (.sys_clk(clk), .mem(mem), .mem_rdata(mem_rdata));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic io_wr(logic [5:0] a, logic [7:0] d);
        @(negedge clk);
        io = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        io.we = 1'b0;
    endtask
    task automatic io_rd(logic [5:0] a);
        @(negedge clk);
        io = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        io.re = 1'b0;
        rd = io_rdata;
    endtask
    // Counts cycles from the first cycle after the request edge.
    task automatic wait_load();
        n = 1;
        while (pc_load !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic do_op(csis_op_e o, logic [7:0] d);
        @(negedge clk);
        op = '{1'b1, o, d};
        @(negedge clk);
        op.valid = 1'b0;
        n = 1;
        while (op_done !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        pc_seen = pc_out;
        @(negedge clk);
    endtask

    initial begin
        #20us;
        n_mismatch++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        io = '0;
        op = '0;
        alu = '0;
        pc_in = 16'h1234;
        iend = 1'b0;
        sleeping = 1'b0;
        ev = 8'h00;
        cond = 8'h00;
        en = 8'hf7;
        w1c = 8'h00;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        io_rd(A_L);
        check("sp_low_reset", rd, TOP_OF_DATA_RAM[7:0]);
        io_rd(A_H);
        check("sp_high_reset", rd, TOP_OF_DATA_RAM[15:8]);
        io_wr(A_H, 8'hff);
        io_rd(A_H);
        check("sp_high_mask", rd, 8'((1 << (SP_BITS - 8)) - 1));
        io_rd(6'h20);
        check("unmapped", rd, 8'h00);
        io_wr(A_H, 8'h01);
        io_wr(A_L, 8'h00);
        @(negedge clk);
        alu = '{1'b1, ALU_ADD, 8'h12, 8'h34};
        @(negedge clk);
        alu.valid = 1'b0;
        check("alu_add", {alu_v, alu_res}, 9'h146);
        do_op(OP_PUSH1, 8'ha5);
        check("push_mem", sram.ram[10'h100], 8'ha5);
        io_rd(A_L);
        check("push_sp", rd, 8'hff);
        do_op(OP_POP1, 8'h00);
        check("pop_data", pop_data, 8'ha5);
        io_rd(A_L);
        check("pop_sp", rd, 8'h00);
        do_op(OP_CALL, 8'h00);
        check("call_cycles", n, 2);
        stk = {sram.ram[10'h100], sram.ram[10'h0ff]};
        check("call_push", stk, 16'h3412);
        io_rd(A_L);
        check("call_sp", rd, 8'hfe);
        do_op(OP_RET, 8'h00);
        check("ret_pc", pc_seen, 16'h1234);
        io_rd(A_L);
        check("ret_sp", rd, 8'h00);
        // Flags raised with the global enable off must wait.
        @(negedge clk);
        ev = 8'h68;
        @(negedge clk);
        ev = 8'h00;
        iend = 1'b1;
        @(negedge clk);
        iend = 1'b0;
        check("held", {stall, flags}, 9'h068);
        @(negedge clk);
        op = '{1'b1, OP_SEI, 8'h00};
        iend = 1'b1;
        @(negedge clk);
        op.valid = 1'b0;
        iend = 1'b0;
        check("sei_defer", {gie, stall}, 2'b10);
        pc_in = 16'h0abc;
        @(negedge clk);
        iend = 1'b1;
        @(negedge clk);
        iend = 1'b0;
        wait_load();
        check("entry_cycles", n, ENTRY_CYCLES - 1);
        check("entry_vector", {vec, pc_out}, 20'h60006);
        check("entry_flags", {gie, flags}, 9'h048);
        stk = {sram.ram[10'h100], sram.ram[10'h0ff]};
        check("entry_push", stk, 16'hbc0a);
        @(negedge clk);
        w1c = 8'h08;
        cond = 8'h01;
        @(negedge clk);
        w1c = 8'h00;
        cond = 8'h00;
        check("w1c", flags, 8'h40);
        do_op(OP_RETURN_FROM_HANDLER_INSTR, 8'h00);
        check("return_from_handler_instr_cycles", n, RETURN_CYCLES - 1);
        check("return_from_handler_instr_pc", {gie, pc_seen}, 17'h10abc);
        io_rd(A_L);
        check("return_from_handler_instr_sp", rd, 8'h00);
        @(negedge clk);
        op = '{1'b1, OP_CLI, 8'h00};
        iend = 1'b1;
        @(negedge clk);
        op.valid = 1'b0;
        iend = 1'b0;
        check("cli_now", {gie, stall, flags}, 10'h040);
        do_op(OP_SEI, 8'h00);
        // Level source 0 lost its condition, so only source 6 may win.
        sleeping = 1'b1;
        @(negedge clk);
        wait_load();
        sleeping = 1'b0;
        check("wake_n", n, ENTRY_CYCLES + WAKE_EXTRA_CYCLES - 1);
        check("wake_vector", {vec, flags}, 12'h700);
        // No boundary and no sleep here, so setting the enable takes nothing.
        io_wr(CPU_FLAGS_REGISTER_ADDR, 8'h80);
        io_rd(CPU_FLAGS_REGISTER_ADDR);
        check("flags_gie", {gie, rd}, 9'h180);
        @(negedge clk);
        alu = '{1'b1, ALU_SUB, 8'h12, 8'h34};
        @(negedge clk);
        alu.valid = 1'b0;
        check("alu_sub", {alu_v, alu_res}, 9'h1de);
        io_rd(CPU_FLAGS_REGISTER_ADDR);
        check("alu_flags", rd, 8'h81);
        complete_run();
    end
endmodule
